// >>> common/ocd_pkg.sv
package ocd_pkg;
  localparam logic [7:0] OCD_CMD_REG = 8'h71;
  localparam logic [7:0] OCD_CMD_SPLIT = 8'h72;
  localparam logic [7:0] OCD_REG_RST = 8'h5C;
  localparam logic [1:0] OCD_SPLIT_RST = 2'h0;
  localparam logic [1:0] OCD_ROM_RST = 2'h0;
  localparam logic [6:0] OCD_AC_RST = 7'h00;
  localparam logic [5:0] OCD_SQ_RST = 6'h00;
  localparam logic [5:0] OCD_SQ_MAX = 6'h30;
  localparam int OCD_TEXT_DEPTH = 128;
  localparam int OCD_GLYPH_DEPTH = 64;
  localparam int OCD_BUSY_CYCLES = 2;
  typedef enum logic [1:0] {OCD_PEND_NONE, OCD_PEND_REG, OCD_PEND_SPLIT} ocd_pend_t;
endpackage

// >>> src/ocd_decoder.sv
`timescale 1ns/100ps
module ocd_decoder
  import ocd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req,
  input wire logic dc,
  input wire logic rd,
  input wire logic [7:0] din,
  input wire logic [6:0] part_identifier,
  output logic [7:0] dout,
  output logic dout_valid,
  output logic busy_flag,
  output logic glyph_blink_en,
  output logic display_invert,
  output logic ext_state_bit,
  output logic special_state_bit,
  output logic oled_set_state_bit,
  output logic four_line_mode,
  output logic line_count,
  output logic [1:0] line_sel,
  output logic [6:0] addr_counter,
  output logic sel_glyph,
  output logic [5:0] scroll_qty,
  output logic scroll_invalid,
  output logic [7:0] regulator_sel,
  output logic [1:0] glyph_split_sel,
  output logic [1:0] rom_sel,
  output logic rom_invalid
);
  import ocd_pkg::*;
  // ==========================================================
  // next state
  logic [7:0] text_memory [OCD_TEXT_DEPTH];
  logic [7:0] user_glyph_memory [OCD_GLYPH_DEPTH];
  logic [7:0] next_dout;
  logic next_dout_valid;
  logic next_blink;
  logic next_inv;
  logic next_ext;
  logic next_is;
  logic next_sd;
  logic next_lines;
  logic next_nw;
  logic [1:0] next_line_sel;
  logic next_sel_glyph;
  logic next_second;
  logic second_read;
  logic [6:0] next_ac;
  logic [5:0] next_sq;
  logic next_sq_invalid;
  logic [7:0] next_reg;
  logic [1:0] next_split;
  logic [1:0] next_rom;
  logic next_rom_invalid;
  logic [1:0] busy_cnt;
  logic [1:0] next_busy_cnt;
  logic next_busy_flag;
  ocd_pend_t pend;
  ocd_pend_t next_pend;
  logic wr_en;
  logic [7:0] mem_rd;
  always_comb begin
    mem_rd = sel_glyph ? user_glyph_memory[addr_counter[5:0]] : text_memory[addr_counter];
    next_dout = dout;
    next_dout_valid = 1'b0;
    next_blink = glyph_blink_en;
    next_inv = display_invert;
    next_ext = ext_state_bit;
    next_is = special_state_bit;
    next_sd = oled_set_state_bit;
    next_lines = line_count;
    next_nw = four_line_mode;
    next_sel_glyph = sel_glyph;
    next_second = second_read;
    next_ac = addr_counter;
    next_sq = scroll_qty;
    next_reg = regulator_sel;
    next_split = glyph_split_sel;
    next_rom = rom_sel;
    next_pend = pend;
    next_busy_cnt = (busy_cnt != 2'h0) ? busy_cnt - 2'h1 : 2'h0;
    wr_en = 1'b0;
    if (req && !oled_set_state_bit || req && dc) begin
      if (!dc && rd) begin
        next_dout = {busy_cnt != 2'h0, second_read ? part_identifier : addr_counter};
        next_second = !second_read;
        next_dout_valid = 1'b1;
      end else if (dc && rd) begin
        next_dout = mem_rd;
        next_dout_valid = 1'b1;
        next_second = 1'b0;
      end else if (dc) begin
        next_second = 1'b0;
        next_pend = OCD_PEND_NONE;
        if (pend == OCD_PEND_REG) begin
          next_reg = din;
        end else if (pend == OCD_PEND_SPLIT) begin
          next_split = din[1:0];
          next_rom = din[3:2];
        end else begin
          wr_en = 1'b1;
          next_busy_cnt = 2'(OCD_BUSY_CYCLES);
        end
      end else begin
        next_second = 1'b0;
        next_pend = OCD_PEND_NONE;
        next_busy_cnt = 2'(OCD_BUSY_CYCLES);
        if (din[7:5] == 3'h1) begin
          next_lines = din[3];
          next_ext = din[1];
          if (ext_state_bit) begin
            next_blink = din[2];
            next_inv = din[0];
          end else begin
            next_is = din[0];
          end
        end else if (din[7] && !ext_state_bit) begin
          next_ac = din[6:0];
          next_sel_glyph = 1'b0;
        end else if (din[7]) begin
          next_sq = din[5:0];
        end else if (din[7:6] == 2'h1 && !ext_state_bit && !special_state_bit) begin
          next_ac = {1'b0, din[5:0]};
          next_sel_glyph = 1'b1;
        end else if (ext_state_bit && din == OCD_CMD_REG) begin
          next_pend = OCD_PEND_REG;
        end else if (ext_state_bit && din == OCD_CMD_SPLIT) begin
          next_pend = OCD_PEND_SPLIT;
        end else if (ext_state_bit && din[7:1] == 7'h3C) begin
          next_sd = din[0];
        end else if (din[7:3] == 5'h01 && ext_state_bit) begin
          next_busy_cnt = 2'(OCD_BUSY_CYCLES);
          next_nw = din[0];
        end
      end
    end else if (req && !rd && din[7:1] == 7'h3C && ext_state_bit) begin
      next_sd = din[0];
    end
    next_line_sel = {next_nw, next_lines};
    next_busy_flag = next_busy_cnt != 2'h0;
    next_sq_invalid = next_sq > OCD_SQ_MAX;
    next_rom_invalid = next_rom == 2'h3;
  end
  // ==========================================================
  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dout <= 8'h00;
      dout_valid <= 1'b0;
      glyph_blink_en <= 1'b0;
      display_invert <= 1'b0;
      ext_state_bit <= 1'b0;
      special_state_bit <= 1'b0;
      oled_set_state_bit <= 1'b0;
      line_count <= 1'b0;
      sel_glyph <= 1'b0;
      second_read <= 1'b0;
      addr_counter <= OCD_AC_RST;
      scroll_qty <= OCD_SQ_RST;
      regulator_sel <= OCD_REG_RST;
      glyph_split_sel <= OCD_SPLIT_RST;
      rom_sel <= OCD_ROM_RST;
      pend <= OCD_PEND_NONE;
      busy_cnt <= 2'h0;
      busy_flag <= 1'b0;
      four_line_mode <= 1'b0;
      line_sel <= 2'h0;
      scroll_invalid <= 1'b0;
      rom_invalid <= 1'b0;
    end else begin
      dout <= next_dout;
      dout_valid <= next_dout_valid;
      glyph_blink_en <= next_blink;
      display_invert <= next_inv;
      ext_state_bit <= next_ext;
      special_state_bit <= next_is;
      oled_set_state_bit <= next_sd;
      line_count <= next_lines;
      sel_glyph <= next_sel_glyph;
      second_read <= next_second;
      addr_counter <= next_ac;
      scroll_qty <= next_sq;
      regulator_sel <= next_reg;
      glyph_split_sel <= next_split;
      rom_sel <= next_rom;
      pend <= next_pend;
      busy_cnt <= next_busy_cnt;
      busy_flag <= next_busy_flag;
      four_line_mode <= next_nw;
      line_sel <= next_line_sel;
      scroll_invalid <= next_sq_invalid;
      rom_invalid <= next_rom_invalid;
    end
  end
  // ==========================================================
  // memories
  genvar gi;
  generate
    for (gi = 0; gi < OCD_TEXT_DEPTH; gi++) begin : g_text
      logic [7:0] next_entry;
      always_comb begin
        next_entry = text_memory[gi];
        if (wr_en && !sel_glyph && addr_counter == 7'(gi)) begin
          next_entry = din;
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          text_memory[gi] <= 8'h00;
        end else begin
          text_memory[gi] <= next_entry;
        end
      end
    end
    for (gi = 0; gi < OCD_GLYPH_DEPTH; gi++) begin : g_glyph
      logic [7:0] next_entry;
      always_comb begin
        next_entry = user_glyph_memory[gi];
        if (wr_en && sel_glyph && addr_counter[5:0] == 6'(gi)) begin
          next_entry = din;
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          user_glyph_memory[gi] <= 8'h00;
        end else begin
          user_glyph_memory[gi] <= next_entry;
        end
      end
    end
  endgenerate
  // ==========================================================
  // checks
  logic cmd_wr;
  logic stat_rd;
  logic data_wr;
  logic data_rd;
  always_comb begin
    cmd_wr = req && !dc && !rd && !oled_set_state_bit;
    stat_rd = req && !dc && rd && !oled_set_state_bit;
    data_wr = req && dc && !rd;
    data_rd = req && dc && rd;
  end
  a_invert_load: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && din[7:5] == 3'h1 && ext_state_bit
    |=> display_invert == $past(din[0]) && glyph_blink_en == $past(din[2]))
    else $error("invert or blink not loaded");
  a_blink_hold: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && din[7:5] == 3'h1 && !ext_state_bit
    |=> glyph_blink_en == $past(glyph_blink_en) && special_state_bit == $past(din[0]))
    else $error("blink changed outside extension");
  a_ext_update: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && din[7:5] == 3'h1
    |=> ext_state_bit == $past(din[1]) && line_count == $past(din[3]))
    else $error("extension bit not loaded");
  a_nw_load: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && ext_state_bit && din[7:3] == 5'h01
    |=> four_line_mode == $past(din[0]) && line_sel == {$past(din[0]), line_count})
    else $error("line mode not loaded");
  a_text_addr: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && din[7] && !ext_state_bit
    |=> addr_counter == $past(din[6:0]) && !sel_glyph)
    else $error("text address not loaded");
  a_glyph_addr: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && din[7:6] == 2'h1 && !ext_state_bit && !special_state_bit
    |=> addr_counter == {1'b0, $past(din[5:0])} && sel_glyph)
    else $error("glyph address not loaded");
  a_scroll_load: assert property (@(posedge clock) disable iff (rst)
    cmd_wr && din[7] && ext_state_bit
    |=> scroll_qty == $past(din[5:0]) && scroll_invalid == ($past(din[5:0]) > OCD_SQ_MAX))
    else $error("scroll quantity not loaded");
  a_status_busy: assert property (@(posedge clock) disable iff (rst)
    stat_rd |=> dout_valid && dout[7] == $past(busy_flag))
    else $error("status busy bit wrong");
  a_status_first: assert property (@(posedge clock) disable iff (rst)
    stat_rd && !second_read |=> dout[6:0] == $past(addr_counter))
    else $error("first status read not counter");
  a_status_pair: assert property (@(posedge clock) disable iff (rst)
    stat_rd && !second_read ##1 req && !dc && rd
    |=> dout[6:0] == part_identifier)
    else $error("second status read not part id");
  a_read_valid: assert property (@(posedge clock) disable iff (rst)
    data_rd |=> dout_valid)
    else $error("data read not answered");
  a_reg_param: assert property (@(posedge clock) disable iff (rst)
    pend == OCD_PEND_REG && data_wr |=> regulator_sel == $past(din))
    else $error("regulator byte not taken");
  a_split_load: assert property (@(posedge clock) disable iff (rst)
    pend == OCD_PEND_SPLIT && data_wr
    |=> glyph_split_sel == $past(din[1:0]) && rom_sel == $past(din[3:2])
    && rom_invalid == ($past(din[3:2]) == 2'h3))
    else $error("split byte not taken");
  a_pend_clear: assert property (@(posedge clock) disable iff (rst)
    data_wr |=> pend == OCD_PEND_NONE)
    else $error("parameter wait not ended");
  a_write_busy: assert property (@(posedge clock) disable iff (rst)
    data_wr && pend == OCD_PEND_NONE |=> busy_flag)
    else $error("busy not raised");
  a_sd_load: assert property (@(posedge clock) disable iff (rst)
    req && !dc && !rd && ext_state_bit && din[7:1] == 7'h3C
    |=> oled_set_state_bit == $past(din[0]))
    else $error("oled set bit not loaded");
  a_sd_blocks: assert property (@(posedge clock) disable iff (rst)
    req && !dc && !rd && oled_set_state_bit && din[7:1] != 7'h3C
    |=> addr_counter == $past(addr_counter) && scroll_qty == $past(scroll_qty)
    && ext_state_bit == $past(ext_state_bit))
    else $error("command taken while oled set on");
endmodule

// >>> bench/ocd_host.sv
`timescale 1ns/100ps
// ====================
// host model
module ocd_host (
  input wire logic clock,
  input wire logic busy_flag,
  output logic req,
  output logic dc,
  output logic rd,
  output logic [7:0] din,
  output logic hung
);
  initial begin
    req = 1'b0;
    dc = 1'b0;
    rd = 1'b0;
    din = 8'h00;
    hung = 1'b0;
  end
  // byte set up on a falling edge, req left high
  task automatic put(input logic d_c, input logic r_w, input logic [7:0] b, input bit idle_first);
    int n;
    n = 0;
    while (idle_first && busy_flag !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    if (n == 20) begin
      hung = 1'b1;
    end
    req = 1'b1;
    dc = d_c;
    rd = r_w;
    din = b;
    @(negedge clock);
  endtask
  // release: data lines show the inverse
  task automatic idle();
    req = 1'b0;
    din = ~din;
    @(negedge clock);
  endtask
endmodule

// >>> bench/char_oled_cmd_decoder_ext_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: mismatch", $time); end end
module char_oled_cmd_decoder_ext_test;
  import ocd_pkg::*;
  logic clock, rst, req, dc, rd, hung, dout_valid, busy_flag, glyph_blink_en, display_invert;
  logic ext_state_bit, special_state_bit, oled_set_state_bit, four_line_mode, line_count;
  logic sel_glyph, scroll_invalid, rom_invalid;
  logic [1:0] line_sel, glyph_split_sel, rom_sel;
  logic [5:0] scroll_qty, q;
  logic [6:0] part_id, addr_counter, a;
  logic [7:0] din, dout, regulator_sel, v, m;
  int fail_count = 0;
  int compares = 0;
  // ====================
  // instances
  ocd_decoder dut_u (.clock(clock), .rst(rst), .req(req), .dc(dc), .rd(rd), .din(din),
    .part_identifier(part_id), .dout(dout), .dout_valid(dout_valid), .busy_flag(busy_flag),
    .glyph_blink_en(glyph_blink_en), .display_invert(display_invert),
    .ext_state_bit(ext_state_bit), .special_state_bit(special_state_bit),
    .oled_set_state_bit(oled_set_state_bit), .four_line_mode(four_line_mode),
    .line_count(line_count), .line_sel(line_sel), .addr_counter(addr_counter),
    .sel_glyph(sel_glyph), .scroll_qty(scroll_qty), .scroll_invalid(scroll_invalid),
    .regulator_sel(regulator_sel), .glyph_split_sel(glyph_split_sel), .rom_sel(rom_sel),
    .rom_invalid(rom_invalid));
  ocd_host host_u (.clock(clock), .busy_flag(busy_flag), .req(req), .dc(dc), .rd(rd),
    .din(din), .hung(hung));
  // ====================
  // tasks
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic sq_bad(input logic [5:0] s);
    return s > OCD_SQ_MAX;
  endfunction
  task automatic chk_reset();
    `CHK(regulator_sel, OCD_REG_RST)
    `CHK(addr_counter, OCD_AC_RST)
    `CHK({glyph_blink_en, display_invert, oled_set_state_bit}, 3'h0)
    `CHK(scroll_qty, OCD_SQ_RST)
    `CHK({glyph_split_sel, rom_sel}, {OCD_SPLIT_RST, OCD_ROM_RST})
  endtask
  task automatic wr(input logic d_c, input logic [7:0] b);
    host_u.put(d_c, 1'b0, b, ~d_c);
    host_u.idle();
  endtask
  task automatic rd_byte(input logic d_c, input bit wait_busy, output logic [7:0] b);
    host_u.put(d_c, 1'b1, 8'h00, wait_busy);
    `CHK(dout_valid, 1'b1)
    b = dout;
    host_u.idle();
  endtask
  always @(posedge hung) begin
    fail_count++;
    finish_test();
  end
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ====================
  // sequence
  initial begin
    rst = 1'b1;
    void'($urandom(91439));
    part_id = 7'($urandom);
    repeat (3) @(negedge clock);
    rst = 1'b0;
    chk_reset();
    for (int i = 0; i < 16; i++) begin
      a = (i == 0) ? 7'h7F : 7'($urandom);
      if (i[0]) a = {1'b0, 6'($urandom)};
      wr(1'b0, i[0] ? {2'b01, a[5:0]} : {1'b1, a});
      `CHK(addr_counter, a)
      `CHK(sel_glyph, i[0])
      `CHK(busy_flag, 1'b1)
      rd_byte(1'b0, 1'b0, m);
      `CHK(m, {1'b1, a})
      v = 8'($urandom);
      wr(1'b1, v);
      rd_byte(1'b1, 1'b1, m);
      `CHK(m, v)
      host_u.put(1'b0, 1'b1, 8'h00, 1'b1);
      `CHK({dout_valid, dout}, {1'b1, 1'b0, a})
      host_u.put(1'b0, 1'b1, 8'h00, 1'b0);
      `CHK(dout, {1'b0, part_id})
      host_u.idle();
      v = 8'($urandom);
      wr(1'b0, {3'b001, v[4:2], 2'b10});
      `CHK({ext_state_bit, special_state_bit, glyph_blink_en}, 3'h4)
      wr(1'b0, {3'b001, v[4:2], 1'b1, v[0]});
      `CHK({ext_state_bit, line_count}, {1'b1, v[3]})
      `CHK({glyph_blink_en, display_invert}, {v[2], v[0]})
      wr(1'b0, {5'b00001, 2'b00, v[5]});
      `CHK({four_line_mode, line_sel}, {v[5], v[5], v[3]})
      q = (i < 2) ? 6'(6'h30 + i) : 6'($urandom);
      wr(1'b0, {1'b1, v[6], q});
      `CHK({scroll_qty, scroll_invalid}, {q, sq_bad(q)})
      host_u.put(1'b0, 1'b0, OCD_CMD_SPLIT, 1'b1);
      host_u.put(1'b1, 1'b0, {4'($urandom), 4'(i)}, 1'b0);
      host_u.idle();
      `CHK(glyph_split_sel, 2'(i))
      `CHK({rom_sel, rom_invalid}, {2'(i >> 2), i >= 12})
      m = i[0] ? 8'h00 : 8'($urandom);
      host_u.put(1'b0, 1'b0, OCD_CMD_REG, 1'b1);
      host_u.put(1'b1, 1'b0, m, 1'b0);
      host_u.idle();
      `CHK(regulator_sel, m)
      wr(1'b0, 8'h79);
      `CHK(oled_set_state_bit, 1'b1)
      wr(1'b0, 8'h80);
      `CHK(scroll_qty, q)
      wr(1'b0, 8'h78);
      `CHK(oled_set_state_bit, 1'b0)
      wr(1'b0, 8'h20);
      `CHK(ext_state_bit, 1'b0)
    end
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    chk_reset();
    wr(1'b0, 8'h80);
    rd_byte(1'b1, 1'b1, m);
    `CHK(m, 8'h00)
    finish_test();
  end
endmodule
